// ==== src/mie_consts.vh ====
// constants for the instruction execute block
`ifndef MIE_CONSTS_VH
`define MIE_CONSTS_VH
// ==========================================================
// opcode encodings (5-bit operation select)
`define MIE_OP_NOP       5'h00
`define MIE_OP_MOV_MA    5'h01
`define MIE_OP_MOV_AM    5'h02
`define MIE_OP_MOV_AX    5'h03
`define MIE_OP_BCLR      5'h04
`define MIE_OP_BSET      5'h05
`define MIE_OP_JUMP      5'h06
`define MIE_OP_SZ        5'h07
`define MIE_OP_SKZ_COPY  5'h08
`define MIE_OP_SZB       5'h09
`define MIE_OP_SNZB      5'h0A
`define MIE_OP_INC_SKZ   5'h0B
`define MIE_OP_DEC_SKZ   5'h0C
`define MIE_OP_INC_SKZ_A 5'h0D
`define MIE_OP_DEC_SKZ_A 5'h0E
`define MIE_OP_CALL      5'h0F
`define MIE_OP_RET       5'h10
`define MIE_OP_RETA      5'h11
`define MIE_OP_IRET      5'h12
`define MIE_OP_TBLC      5'h13
`define MIE_OP_TBLL      5'h14
`define MIE_OP_CLRM      5'h15
`define MIE_OP_SETM      5'h16
`define MIE_OP_CLRWDT    5'h17
`define MIE_OP_WDT1      5'h18
`define MIE_OP_WDT2      5'h19
`define MIE_OP_SWAP      5'h1A
`define MIE_OP_SWAP_A    5'h1B
`define MIE_OP_HALT      5'h1C
`define MIE_OP_ADD       5'h1D
`define MIE_OP_ADC       5'h1E
`define MIE_OP_ADDX      5'h1F
// secondary ops share codes via the 2-bit sub field: see sub-op select
`define MIE_SUB_ADD_MEM  2'h1
`define MIE_SUB_ADC_MEM  2'h2
`define MIE_SUB_AND      2'h3
// ==========================================================
// reset values and cycle counts
`define MIE_ACC_RST      8'h00
`define MIE_FLAG_RST     1'b0
`define MIE_CYC_ONE      2'h1
`define MIE_CYC_TWO      2'h2
// data address of the program counter low byte
`define MIE_PC_LOW_ADDR  8'h06
`endif

// ==== src/mie_core.v ====
// instruction execute stage of an 8-bit accumulator core
`timescale 1ns/1ps
// Function
// - moves between memory, accumulator and immediate take one cycle, no flags.
// - bit clear or set of a memory byte takes one cycle, no flags.
// - anything writing program counter low byte takes two cycles.
// - skips take two cycles when skipping, one when falling through.
// - skip on byte zero, bit zero, bit non-zero; no flags.
// - inc/dec-and-skip write result to memory or accumulator, skip on zero.
// - zero-skip with copy loads tested byte into accumulator.
// - table fetch current or last page; high to table register, two cycles.
// - single watchdog clear: one cycle, restart, clear both flags.
// - pre-clear pair executed back to back clears both flags.
// - pre-clears not consecutive leave both flags unchanged.
// - halt takes one cycle, enters power-down, updates both flags.
// - nibble swap to memory or accumulator, one cycle, no flags.
// - returns take two cycles; immediate form loads accumulator.
// - add with carry sums accumulator, byte, carry into accumulator.
// - memory forms of add and add-with-carry write sum to memory.
// - plain add of byte to accumulator updates four flags.
// - add immediate to accumulator updates four flags.
// - AND with byte into accumulator updates zero flag only.
// - AND with immediate into accumulator updates zero flag only.
// - memory AND writes result back to byte, updates zero flag.
// - zero flag set on all-zero result, cleared otherwise.
`include "mie_consts.vh"

module mie_core
#(
  parameter PC_LOW_ADDR = `MIE_PC_LOW_ADDR
)
(
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // instruction issue: one-cycle strobe with its fields
  input wire issue_i,
  input wire [4:0] op_i,
  input wire [1:0] sub_i,
  input wire [7:0] addr_i,
  input wire [2:0] bit_i,
  input wire [7:0] imm_i,
  input wire [7:0] mem_rdata_i,
  // table fetch source: program word returned for the page chosen
  input wire [15:0] prog_word_i,
  // data memory write port
  output reg mem_we_o,
  output reg [7:0] mem_addr_o,
  output reg [7:0] mem_wdata_o,
  // table page request
  output reg tbl_last_page_o,
  // architectural state
  output reg [7:0] acc_o,
  output reg [7:0] table_high_byte_o,
  output reg carry_flag_o,
  output reg zero_flag_o,
  output reg half_carry_flag_o,
  output reg signed_excess_flag_o,
  output reg watchdog_expiry_flag_o,
  output reg powerdown_flag_o,
  // sequencing
  output reg busy_o,
  output reg skip_o,
  output reg pc_load_o,
  output reg watchdog_restart_o,
  output reg halt_o,
  output reg done_o
);

  // ==========================================================
  // helpers
  function [7:0] mie_swap;
    input [7:0] v;
    begin
      mie_swap = {v[3:0], v[7:4]};
    end
  endfunction

  // set or clear bit n of v
  function [7:0] mie_bitop;
    input [7:0] v;
    input [2:0] n;
    input val;
    reg [7:0] m;
    begin
      m = 8'h01 << n;
      mie_bitop = val ? (v | m) : (v & ~m);
    end
  endfunction

  // ==========================================================
  // adder with flag generation
  reg [7:0] add_b;
  reg add_cin;
  wire [4:0] lo_sum;
  wire [8:0] full_sum;
  wire [7:0] sum8;
  wire sum_excess;

  assign lo_sum = {1'b0, acc_o[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
  assign full_sum = {1'b0, acc_o} + {1'b0, add_b} + {8'h00, add_cin};
  assign sum8 = full_sum[7:0];
  // overflow: operands agree in sign, result differs
  assign sum_excess = (acc_o[7] == add_b[7]) && (sum8[7] != acc_o[7]);

  // ==========================================================
  // pre-clear pairing state
  reg prev_first;
  reg prev_second;
  // extra-cycle counter: 0 idle, 1 second cycle pending
  reg stall;

  // ==========================================================
  // next-state decode
  reg next_we;
  reg [7:0] next_wdata;
  reg next_acc_we;
  reg [7:0] next_acc;
  reg next_flags4;
  reg next_zf_we;
  reg next_zf;
  reg next_skip;
  reg next_pc;
  reg next_two;
  reg next_tbl;
  reg next_wdt_clr;
  reg next_wdt_restart;
  reg next_halt;
  reg next_first;
  reg next_second;
  reg [7:0] res;

  always @*
  begin
    next_we = 1'b0;
    next_wdata = 8'h00;
    next_acc_we = 1'b0;
    next_acc = acc_o;
    next_flags4 = 1'b0;
    next_zf_we = 1'b0;
    next_zf = 1'b0;
    next_skip = 1'b0;
    next_pc = 1'b0;
    next_two = 1'b0;
    next_tbl = 1'b0;
    next_wdt_clr = 1'b0;
    next_wdt_restart = 1'b0;
    next_halt = 1'b0;
    next_first = 1'b0;
    next_second = 1'b0;
    add_b = mem_rdata_i;
    add_cin = 1'b0;
    res = 8'h00;
    case (op_i)
      `MIE_OP_MOV_MA:
      begin
        next_acc_we = 1'b1;
        next_acc = mem_rdata_i;
      end
      `MIE_OP_MOV_AM:
      begin
        next_we = 1'b1;
        next_wdata = acc_o;
      end
      `MIE_OP_MOV_AX:
      begin
        next_acc_we = 1'b1;
        next_acc = imm_i;
      end
      `MIE_OP_BCLR, `MIE_OP_BSET:
      begin
        next_we = 1'b1;
        next_wdata = mie_bitop(mem_rdata_i, bit_i, op_i == `MIE_OP_BSET);
      end
      `MIE_OP_JUMP, `MIE_OP_CALL, `MIE_OP_RET, `MIE_OP_IRET, `MIE_OP_RETA:
      begin
        next_pc = 1'b1;
        next_two = 1'b1;
        next_acc_we = (op_i == `MIE_OP_RETA);
        next_acc = imm_i;
      end
      `MIE_OP_SZ:
        next_skip = (mem_rdata_i == 8'h00);
      `MIE_OP_SKZ_COPY:
      begin
        next_skip = (mem_rdata_i == 8'h00);
        next_acc_we = 1'b1;
        next_acc = mem_rdata_i;
      end
      `MIE_OP_SZB, `MIE_OP_SNZB:
        next_skip = mem_rdata_i[bit_i] == (op_i == `MIE_OP_SNZB);
      `MIE_OP_INC_SKZ, `MIE_OP_DEC_SKZ, `MIE_OP_INC_SKZ_A, `MIE_OP_DEC_SKZ_A:
      begin
        if (op_i == `MIE_OP_INC_SKZ || op_i == `MIE_OP_INC_SKZ_A)
          res = mem_rdata_i + 8'h01;
        else
          res = mem_rdata_i - 8'h01;
        next_skip = (res == 8'h00);
        if (op_i == `MIE_OP_INC_SKZ_A || op_i == `MIE_OP_DEC_SKZ_A)
        begin
          next_acc_we = 1'b1;
          next_acc = res;
        end
        else
        begin
          next_we = 1'b1;
          next_wdata = res;
        end
      end
      `MIE_OP_TBLC, `MIE_OP_TBLL:
      begin
        next_tbl = 1'b1;
        next_two = 1'b1;
      end
      `MIE_OP_CLRM, `MIE_OP_SETM:
      begin
        next_we = 1'b1;
        next_wdata = (op_i == `MIE_OP_SETM) ? 8'hFF : 8'h00;
      end
      `MIE_OP_CLRWDT:
      begin
        next_wdt_clr = 1'b1;
        next_wdt_restart = 1'b1;
      end
      `MIE_OP_WDT1:
      begin
        next_first = 1'b1;
        // completes the pair only right after the second
        next_wdt_clr = prev_second;
        next_wdt_restart = prev_second;
      end
      `MIE_OP_WDT2:
      begin
        next_second = 1'b1;
        next_wdt_clr = prev_first;
        next_wdt_restart = prev_first;
      end
      `MIE_OP_SWAP:
      begin
        next_we = 1'b1;
        next_wdata = mie_swap(mem_rdata_i);
      end
      `MIE_OP_SWAP_A:
      begin
        next_acc_we = 1'b1;
        next_acc = mie_swap(mem_rdata_i);
      end
      `MIE_OP_HALT:
        next_halt = 1'b1;
      `MIE_OP_ADD, `MIE_OP_ADC, `MIE_OP_ADDX:
      begin
        if (op_i == `MIE_OP_ADDX)
          add_b = imm_i;
        if (op_i == `MIE_OP_ADC || sub_i == `MIE_SUB_ADC_MEM)
          add_cin = carry_flag_o;
        if (sub_i == `MIE_SUB_AND)
        begin
          // AND family: sub selects memory dest via op ADC code
          res = acc_o & add_b;
          next_zf_we = 1'b1;
          next_zf = (res == 8'h00);
          if (op_i == `MIE_OP_ADC)
          begin
            next_we = 1'b1;
            next_wdata = res;
          end
          else
          begin
            next_acc_we = 1'b1;
            next_acc = res;
          end
        end
        else
        begin
          next_flags4 = 1'b1;
          next_zf_we = 1'b1;
          next_zf = (sum8 == 8'h00);
          if (sub_i == `MIE_SUB_ADD_MEM || sub_i == `MIE_SUB_ADC_MEM)
          begin
            next_we = 1'b1;
            next_wdata = sum8;
          end
          else
          begin
            next_acc_we = 1'b1;
            next_acc = sum8;
          end
        end
      end
      default:
        next_two = 1'b0;
    endcase
    // memory write aimed at the program counter low byte
    if (next_we && addr_i == PC_LOW_ADDR)
    begin
      next_pc = 1'b1;
      next_two = 1'b1;
    end
    if (next_skip)
      next_two = 1'b1;
  end

  // ==========================================================
  // execute and sequence; issue ignored while busy
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mem_we_o <= 1'b0;
      mem_addr_o <= 8'h00;
      mem_wdata_o <= 8'h00;
      tbl_last_page_o <= 1'b0;
      acc_o <= `MIE_ACC_RST;
      table_high_byte_o <= 8'h00;
      carry_flag_o <= `MIE_FLAG_RST;
      zero_flag_o <= `MIE_FLAG_RST;
      half_carry_flag_o <= `MIE_FLAG_RST;
      signed_excess_flag_o <= `MIE_FLAG_RST;
      watchdog_expiry_flag_o <= `MIE_FLAG_RST;
      powerdown_flag_o <= `MIE_FLAG_RST;
      busy_o <= 1'b0;
      skip_o <= 1'b0;
      pc_load_o <= 1'b0;
      watchdog_restart_o <= 1'b0;
      halt_o <= 1'b0;
      done_o <= 1'b0;
      prev_first <= 1'b0;
      prev_second <= 1'b0;
      stall <= 1'b0;
    end
    else
    begin
      mem_we_o <= 1'b0;
      skip_o <= 1'b0;
      pc_load_o <= 1'b0;
      watchdog_restart_o <= 1'b0;
      halt_o <= 1'b0;
      done_o <= 1'b0;
      if (stall)
      begin
        // second cycle: only ends the stall and raises done; table word was taken at issue
        stall <= 1'b0;
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end
      else if (issue_i)
      begin
        mem_addr_o <= addr_i;
        mem_we_o <= next_we;
        mem_wdata_o <= next_wdata;
        skip_o <= next_skip;
        pc_load_o <= next_pc;
        watchdog_restart_o <= next_wdt_restart;
        halt_o <= next_halt;
        prev_first <= next_first;
        prev_second <= next_second;
        if (next_tbl)
        begin
          // fetched word: high half to table register, low to memory
          tbl_last_page_o <= (op_i == `MIE_OP_TBLL);
          table_high_byte_o <= prog_word_i[15:8];
          mem_we_o <= 1'b1;
          mem_wdata_o <= prog_word_i[7:0];
        end
        if (next_acc_we)
          acc_o <= next_acc;
        if (next_flags4)
        begin
          carry_flag_o <= full_sum[8];
          half_carry_flag_o <= lo_sum[4];
          signed_excess_flag_o <= sum_excess;
        end
        if (next_zf_we)
          zero_flag_o <= next_zf;
        if (next_wdt_clr)
        begin
          watchdog_expiry_flag_o <= 1'b0;
          powerdown_flag_o <= 1'b0;
        end
        if (next_halt)
        begin
          watchdog_expiry_flag_o <= 1'b0;
          powerdown_flag_o <= 1'b1;
        end
        if (next_two)
        begin
          stall <= 1'b1;
          busy_o <= 1'b1;
        end
        else
          done_o <= 1'b1;
      end
    end
  end

endmodule

// ==== verif/mie_core_sva.sv ====
// port checker for the instruction execute stage
`timescale 1ns/1ps
`include "mie_consts.vh"
// ==========================================================
// checker module
module mie_core_sva
#(
  parameter PC_LOW_ADDR = `MIE_PC_LOW_ADDR
)
(
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // issue fields
  input wire issue_i,
  input wire [4:0] op_i,
  input wire [1:0] sub_i,
  input wire [7:0] addr_i,
  input wire [7:0] imm_i,
  input wire [7:0] mem_rdata_i,
  // results and sequencing
  input wire mem_we_o,
  input wire [7:0] mem_addr_o,
  input wire [7:0] mem_wdata_o,
  input wire [7:0] acc_o,
  input wire carry_flag_o,
  input wire zero_flag_o,
  input wire watchdog_expiry_flag_o,
  input wire powerdown_flag_o,
  input wire busy_o,
  input wire skip_o,
  input wire pc_load_o,
  input wire halt_o,
  input wire done_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // an issue counts only when the core is free
  wire take = issue_i && !busy_o;
  sequence s_take(logic [4:0] op);
    take && op_i == op;
  endsequence
  // pre-clear pair, and a pair broken by another issue
  sequence s_pair;
    s_take(`MIE_OP_WDT1) ##1 s_take(`MIE_OP_WDT2);
  endsequence
  sequence s_broken;
    s_take(`MIE_OP_NOP) ##1 s_take(`MIE_OP_WDT2);
  endsequence
  AST_BUSY_ONE: assert property (busy_o |=> !busy_o && done_o)
    else $error("busy held longer than one cycle");
  AST_SKIP_TWO: assert property (skip_o |-> busy_o)
    else $error("taken skip without second cycle");
  AST_MOVE: assert property (s_take(`MIE_OP_MOV_MA) |=>
    acc_o == $past(mem_rdata_i) && !busy_o
    && $stable(zero_flag_o) && $stable(carry_flag_o))
    else $error("memory to accumulator move wrong");
  AST_STORE: assert property (s_take(`MIE_OP_MOV_AM) |=> mem_we_o
    && mem_addr_o == $past(addr_i) && mem_wdata_o == $past(acc_o))
    else $error("accumulator store wrong");
  AST_PC_LOW: assert property (take && op_i == `MIE_OP_MOV_AM
    && addr_i == PC_LOW_ADDR |=> busy_o && pc_load_o ##1 done_o)
    else $error("store to program counter low not two cycles");
  AST_JUMP: assert property (s_take(`MIE_OP_JUMP) |=>
    pc_load_o && busy_o ##1 done_o && !busy_o)
    else $error("jump did not load counter over two cycles");
  AST_ADD_IMM: assert property (take && op_i == `MIE_OP_ADDX
    && sub_i == 2'h0 |=> {carry_flag_o, acc_o} == $past(acc_o) + $past(imm_i)
    && zero_flag_o == (acc_o == 8'h00))
    else $error("immediate add sum or flags wrong");
  AST_AND: assert property (take && op_i == `MIE_OP_ADD
    && sub_i == 2'h3 |=> acc_o == ($past(acc_o) & $past(mem_rdata_i))
    && $stable(carry_flag_o) && zero_flag_o == (acc_o == 8'h00))
    else $error("and into accumulator wrong");
  AST_HALT: assert property (s_take(`MIE_OP_HALT) |=> halt_o
    && powerdown_flag_o && !watchdog_expiry_flag_o && done_o)
    else $error("halt effects wrong");
  AST_PAIR: assert property (s_pair |=>
    !powerdown_flag_o && !watchdog_expiry_flag_o)
    else $error("pre-clear pair did not clear flags");
  AST_BROKEN: assert property (s_broken |=>
    $stable(powerdown_flag_o) && $stable(watchdog_expiry_flag_o))
    else $error("broken pre-clear pair changed flags");
endmodule
bind mie_core mie_core_sva #(.PC_LOW_ADDR(PC_LOW_ADDR)) i_sva (.*);

// ==== verif/mie_tb.sv ====
// self-checking bench for the instruction execute stage
`timescale 1ns/1ps
`include "mie_consts.vh"
// ==========================================================
// bench top
module testbench;
  localparam logic [7:0] PC_LOW_AT = `MIE_PC_LOW_ADDR;
  // design inputs, all defined at time zero
  logic sys_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic issue_i = 1'h0;
  logic [4:0] op_i = 5'h00;
  logic [1:0] sub_i = 2'h0;
  logic [7:0] addr_i = 8'h00;
  logic [2:0] bit_i = 3'h0;
  logic [7:0] imm_i = 8'h00;
  logic [7:0] mem_rdata_i = 8'h00;
  logic [15:0] prog_word_i = 16'h0000;
  // design outputs
  wire mem_we_o, tbl_last_page_o, carry_flag_o, zero_flag_o;
  wire [7:0] mem_addr_o, mem_wdata_o, acc_o, table_high_byte_o;
  wire half_carry_flag_o, signed_excess_flag_o, watchdog_expiry_flag_o;
  wire powerdown_flag_o, busy_o, skip_o, pc_load_o, watchdog_restart_o;
  wire halt_o, done_o;
  wire [3:0] flg = {signed_excess_flag_o, half_carry_flag_o,
    zero_flag_o, carry_flag_o};
  wire [15:0] st = {acc_o, busy_o, done_o, flg,
    watchdog_expiry_flag_o, powerdown_flag_o};
  // bench state
  int err_count = 0;
  int check_count = 0;
  logic c_we, c_sk;
  logic [1:0] c_cy;
  logic [7:0] c_wd;
  logic [41:0] rw;
  // rows: op, sub, bit, operand, acc, wdata, flags, {we,skip,cycles}
  localparam logic [41:0] ROWS [27] = '{
    {`MIE_OP_MOV_AX,2'h0,3'h0,8'h3C,8'h3C,8'h00,4'h0,4'h1},
    {`MIE_OP_ADDX,2'h0,3'h0,8'hC4,8'h00,8'h00,4'h7,4'h1},
    {`MIE_OP_MOV_MA,2'h0,3'h0,8'hF0,8'hF0,8'h00,4'h7,4'h1},
    {`MIE_OP_ADDX,2'h3,3'h0,8'h30,8'h30,8'h00,4'h5,4'h1},
    {`MIE_OP_ADD,2'h3,3'h0,8'hC0,8'h00,8'h00,4'h7,4'h1},
    {`MIE_OP_ADC,2'h0,3'h0,8'h7F,8'h80,8'h00,4'hC,4'h1},
    {`MIE_OP_ADD,2'h0,3'h0,8'h01,8'h81,8'h00,4'h0,4'h1},
    {`MIE_OP_ADD,2'h1,3'h0,8'h80,8'h81,8'h01,4'h9,4'h9},
    {`MIE_OP_ADD,2'h2,3'h0,8'h0E,8'h81,8'h90,4'h4,4'h9},
    {`MIE_OP_ADC,2'h3,3'h0,8'h0F,8'h81,8'h01,4'h4,4'h9},
    {`MIE_OP_MOV_AM,2'h0,3'h0,8'h00,8'h81,8'h81,4'h4,4'h9},
    {`MIE_OP_BCLR,2'h0,3'h7,8'hFF,8'h81,8'h7F,4'h4,4'h9},
    {`MIE_OP_BSET,2'h0,3'h0,8'h00,8'h81,8'h01,4'h4,4'h9},
    {`MIE_OP_SWAP,2'h0,3'h0,8'hA5,8'h81,8'h5A,4'h4,4'h9},
    {`MIE_OP_SWAP_A,2'h0,3'h0,8'h3C,8'hC3,8'h00,4'h4,4'h1},
    {`MIE_OP_SZ,2'h0,3'h0,8'h00,8'hC3,8'h00,4'h4,4'h6},
    {`MIE_OP_SKZ_COPY,2'h0,3'h0,8'h00,8'h00,8'h00,4'h4,4'h6},
    {`MIE_OP_SZB,2'h0,3'h3,8'hF7,8'h00,8'h00,4'h4,4'h6},
    {`MIE_OP_SZB,2'h0,3'h3,8'h08,8'h00,8'h00,4'h4,4'h1},
    {`MIE_OP_SNZB,2'h0,3'h3,8'h08,8'h00,8'h00,4'h4,4'h6},
    {`MIE_OP_INC_SKZ,2'h0,3'h0,8'hFF,8'h00,8'h00,4'h4,4'hE},
    {`MIE_OP_DEC_SKZ,2'h0,3'h0,8'h05,8'h00,8'h04,4'h4,4'h9},
    {`MIE_OP_INC_SKZ_A,2'h0,3'h0,8'h10,8'h11,8'h00,4'h4,4'h1},
    {`MIE_OP_DEC_SKZ_A,2'h0,3'h0,8'h01,8'h00,8'h00,4'h4,4'h6},
    {`MIE_OP_JUMP,2'h0,3'h0,8'h00,8'h00,8'h00,4'h4,4'h2},
    {`MIE_OP_RETA,2'h0,3'h0,8'h9A,8'h9A,8'h00,4'h4,4'h2},
    {`MIE_OP_IRET,2'h0,3'h0,8'h00,8'h9A,8'h00,4'h4,4'h2}};
  // 40 MHz clock
  always #12.5 sys_clk_i = ~sys_clk_i;
  mie_core #(.PC_LOW_ADDR(PC_LOW_AT)) i_dut (.*);
  // compare and count
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    begin
      check_count++;
      if (g !== e)
      begin
        err_count++;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // one instruction; waits out the second cycle so no issue is refused
  task run(input logic [4:0] o, input logic [1:0] s, input logic [2:0] b,
    input logic [7:0] x, input logic [7:0] a, input logic [15:0] w);
    begin
      issue_i <= 1'h1;
      op_i <= o;
      sub_i <= s;
      bit_i <= b;
      imm_i <= x;
      mem_rdata_i <= x;
      addr_i <= a;
      prog_word_i <= w;
      @(posedge sys_clk_i);
      issue_i <= 1'h0;
      #1;
      c_we = mem_we_o;
      c_sk = skip_o;
      c_wd = mem_wdata_o;
      c_cy = 2'h1;
      if (busy_o === 1'h1)
      begin
        c_cy = 2'h2;
        @(posedge sys_clk_i);
        #1;
      end
      chk("done", 16'h0002, {done_o, busy_o});
    end
  endtask
  // operation without operands
  task op1(input logic [4:0] o);
    run(o, 2'h0, 3'h0, 8'h00, 8'h20, 16'h0000);
  endtask
  // verdict, the single exit point
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // watchdog: the whole run needs well under 300 cycles
  initial
  begin
    #(25 * 3000);
    err_count++;
    finish_test;
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    chk("reset", 16'h0000, st);
    for (int i = 0; i < 27; i++)
    begin
      rw = ROWS[i];
      run(rw[41:37], rw[36:35], rw[34:32], rw[31:24], 8'h20, 16'h0000);
      chk("acc", rw[23:16], acc_o);
      chk("flags", rw[7:4], flg);
      chk("ctl", rw[3:0], {c_we, c_sk, c_cy});
      if (rw[3])
        chk("wdata", rw[15:8], c_wd);
    end
    // table fetch from current and last page
    run(`MIE_OP_TBLC, 2'h0, 3'h0, 8'h00, 8'h30, 16'h1234);
    chk("tbl cur", 16'h1234, {table_high_byte_o, c_wd});
    chk("tbl cur ctl", 16'h000A, {c_we, tbl_last_page_o, c_cy});
    run(`MIE_OP_TBLL, 2'h0, 3'h0, 8'h00, 8'h31, 16'hABCD);
    chk("tbl last", 16'hABCD, {table_high_byte_o, c_wd});
    chk("tbl last ctl", 16'h000E, {c_we, tbl_last_page_o, c_cy});
    // store into program counter low costs a second cycle
    run(`MIE_OP_MOV_AM, 2'h0, 3'h0, 8'h00, PC_LOW_AT, 16'h0000);
    chk("pcl store", 16'h000A, {c_we, c_sk, c_cy});
    // issue held into the busy cycle must be dropped
    issue_i <= 1'h1;
    op_i <= `MIE_OP_JUMP;
    @(posedge sys_clk_i);
    op_i <= `MIE_OP_MOV_AX;
    imm_i <= 8'h65;
    @(posedge sys_clk_i);
    issue_i <= 1'h0;
    #1;
    chk("refused", 16'h009A, acc_o);
    // reset in mid-run clears all state
    rst_i <= 1'h1;
    @(posedge sys_clk_i);
    rst_i <= 1'h0;
    #1;
    chk("reset again", 16'h0000, st);
    // halt, consecutive pair, broken pair, single clear
    op1(`MIE_OP_HALT);
    chk("halt", 16'h0015, {halt_o, st[1:0], c_cy});
    op1(`MIE_OP_WDT1);
    op1(`MIE_OP_WDT2);
    chk("pair", 16'h0000, st[1:0]);
    op1(`MIE_OP_HALT);
    op1(`MIE_OP_WDT1);
    op1(`MIE_OP_NOP);
    op1(`MIE_OP_WDT2);
    chk("broken pair", 16'h0001, st[1:0]);
    op1(`MIE_OP_CLRWDT);
    chk("clear", 16'h0011, {watchdog_restart_o, st[1:0], c_cy});
    finish_test;
  end
endmodule
